// ---- pkg/sad_cfg.svh ----
// Purpose: Constants for the segment-select and scale-index-base decoder
// Assumes: Included by bare name; definitions only
// Notes:   Field positions are within the addressing-form and sib bytes
//
// How it works
// - Two-bit segment code maps 00 extra, 01 code, 10 stack, 11 data.
// - Three-bit code maps like narrow, 100 extra two, 101 extra three, 11x none.
// - Scale code 00 gives x1, 01 gives x2, 11 gives x8.
// - Index value times scale factor is one addend of the offset.
// - Index field picks gpr0..3, frame base, gpr6, gpr7; 100 means none.
// - No index adds nothing; nonzero scale then flags an undefined address.
// - Form bits come from addressing byte 7:6, base from sib byte 2:0.
// - When sib follows, take the sib byte and decode form with base.
// - Form 00: base plus index, data segment; base 100 stack, 101 dword.
// - Form 01: adds sign-extended byte; bases 100 and 101 use stack.
// - Form 10: adds dword displacement, segments as form 01.
// - Sib byte splits into scale, index and base fields.
// - Operand select 100 with form other than 11 means sib follows.
`ifndef SAD_CFG_SVH
`define SAD_CFG_SVH

// ==========================================================================
// Field positions
`define SAD_FORM_HI    7
`define SAD_FORM_LO    6
`define SAD_RM_HI      2
`define SAD_RM_LO      0
`define SAD_SCALE_HI   7
`define SAD_SCALE_LO   6
`define SAD_INDEX_HI   5
`define SAD_INDEX_LO   3
`define SAD_BASE_HI    2
`define SAD_BASE_LO    0

// ==========================================================================
// Codes
`define SAD_RM_SIB     3'h4
`define SAD_FORM_NODSP 2'h0
`define SAD_FORM_BYTE  2'h1
`define SAD_FORM_DWORD 2'h2
`define SAD_FORM_REG   2'h3
`define SAD_BASE_STACK 3'h4
`define SAD_BASE_FRAME 3'h5
`define SAD_INDEX_NONE 3'h4
`define SAD_SCALE_ONE  2'h0

// ==========================================================================
// Reset values and timing
`define SAD_RST_REG    3'h0
`define SAD_RST_FACTOR 4'h1
`define SAD_LATENCY    1

`endif

// ---- pkg/sad_pkg.sv ----
// Purpose: Types for the segment-select and scale-index-base decoder
// Assumes: Compiled before the design
// Notes:   Segment codes 0..3 equal the narrow field codes
package sad_pkg;
    typedef enum logic [2:0] {
        SAD_SEG_EXTRA       = 3'h0,
        SAD_SEG_CODE        = 3'h1,
        SAD_SEG_STACK       = 3'h2,
        SAD_SEG_DATA        = 3'h3,
        SAD_SEG_EXTRA_TWO   = 3'h4,
        SAD_SEG_EXTRA_THREE = 3'h5,
        SAD_SEG_NONE        = 3'h7
    } sad_seg_t;

    typedef enum logic [1:0] {
        SAD_DISP_NONE  = 2'h0,
        SAD_DISP_BYTE  = 2'h1,
        SAD_DISP_DWORD = 2'h2
    } sad_disp_t;
endpackage

// ---- design/sad_decode.sv ----
// Purpose: Segment-select and scale-index-base decode for address generation
// Assumes: Inputs come from decode logic on the same clock
// Notes:   One cycle from request to registered result
`timescale 1ns/100ps
`include "sad_cfg.svh"

module sad_decode
    import sad_pkg::*;
#(
    parameter int ADDR_W = 32
)(
    // Clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    reset_i,
    // Segment select fields
    input  wire logic [1:0]              seg_sel_narrow_i,
    input  wire logic [2:0]              seg_sel_wide_i,
    // Instruction bytes
    input  wire logic                    dec_valid_i,
    input  wire logic [7:0]              modrm_i,
    input  wire logic [7:0]              sib_i,
    input  wire logic [31:0]             disp_i,
    // Register file values, gpr0 in the low slot
    input  wire logic [7:0][ADDR_W-1:0]  gpr_i,
    // Segment results
    output sad_seg_t                     seg_narrow_o,
    output sad_seg_t                     seg_wide_o,
    output logic                         seg_wide_undef_o,
    // Address-generation results
    output logic                         sib_follows_o,
    output logic                         agen_valid_o,
    output sad_seg_t                     default_seg_o,
    output logic                         base_used_o,
    output logic [2:0]                   base_reg_o,
    output logic                         index_used_o,
    output logic [2:0]                   index_reg_o,
    output logic [3:0]                   scale_factor_o,
    output sad_disp_t                    disp_size_o,
    output logic [ADDR_W-1:0]            ea_offset_o,
    output logic                         ea_undef_o
);

    // ======================================================================
    // Elaboration check
    if (ADDR_W != 32)
    begin : g_bad_width
        $error("sad_decode: only 32-bit addressing is served");
    end

    // ======================================================================
    // Field extraction
    logic [1:0] form;
    logic [2:0] rm;
    logic [1:0] scale;
    logic [2:0] index;
    logic [2:0] base;

    assign form  = modrm_i[`SAD_FORM_HI:`SAD_FORM_LO];
    assign rm    = modrm_i[`SAD_RM_HI:`SAD_RM_LO];
    assign scale = sib_i[`SAD_SCALE_HI:`SAD_SCALE_LO];
    assign index = sib_i[`SAD_INDEX_HI:`SAD_INDEX_LO];
    assign base  = sib_i[`SAD_BASE_HI:`SAD_BASE_LO];

    // ======================================================================
    // Registers and next values
    sad_seg_t          seg_narrow_r,  seg_narrow_nxt;
    sad_seg_t          seg_wide_r,    seg_wide_nxt;
    logic              wide_undef_r,  wide_undef_nxt;
    logic              sib_r,         sib_nxt;
    logic              valid_r,       valid_nxt;
    sad_seg_t          dseg_r,        dseg_nxt;
    logic              base_used_r,   base_used_nxt;
    logic [2:0]        base_reg_r,    base_reg_nxt;
    logic              idx_used_r,    idx_used_nxt;
    logic [2:0]        idx_reg_r,     idx_reg_nxt;
    logic [3:0]        factor_r,      factor_nxt;
    sad_disp_t         disp_size_r,   disp_size_nxt;
    logic [ADDR_W-1:0] offset_r,      offset_nxt;
    logic              undef_r,       undef_nxt;

    // ======================================================================
    // Segment decode
    always_comb
    begin
        // Narrow codes share the enum encoding, so the cast is exact
        seg_narrow_nxt = sad_seg_t'({1'b0, seg_sel_narrow_i});
        wide_undef_nxt = 1'b0;
        unique case (seg_sel_wide_i)
            3'h0:    seg_wide_nxt = SAD_SEG_EXTRA;
            3'h1:    seg_wide_nxt = SAD_SEG_CODE;
            3'h2:    seg_wide_nxt = SAD_SEG_STACK;
            3'h3:    seg_wide_nxt = SAD_SEG_DATA;
            3'h4:    seg_wide_nxt = SAD_SEG_EXTRA_TWO;
            3'h5:    seg_wide_nxt = SAD_SEG_EXTRA_THREE;
            default:
            begin
                // Codes 110 and 111 select no segment
                seg_wide_nxt   = SAD_SEG_NONE;
                wide_undef_nxt = 1'b1;
            end
        endcase
    end

    // ======================================================================
    // Scale-index-base decode
    logic [1:0]        shift;
    logic [ADDR_W-1:0] base_val;
    logic [ADDR_W-1:0] scaled_idx;
    logic [ADDR_W-1:0] disp_val;

    always_comb
    begin
        sib_nxt   = (rm == `SAD_RM_SIB) && (form != `SAD_FORM_REG);
        valid_nxt = dec_valid_i && sib_nxt;

        unique case (scale)
            2'h0: shift = 2'h0;
            2'h1: shift = 2'h1;
            2'h2: shift = 2'h2;
            2'h3: shift = 2'h3;
        endcase
        factor_nxt = 4'h1 << shift;

        // Index code 100 selects nothing; others name the register slot
        idx_used_nxt = (index != `SAD_INDEX_NONE);
        idx_reg_nxt  = index;
        scaled_idx   = idx_used_nxt ? (gpr_i[index] << shift)
                                    : '0;
        undef_nxt    = !idx_used_nxt && (scale != `SAD_SCALE_ONE);

        base_used_nxt = 1'b1;
        base_reg_nxt  = base;
        dseg_nxt      = SAD_SEG_DATA;
        disp_size_nxt = SAD_DISP_NONE;
        unique case (form)
            `SAD_FORM_NODSP:
            begin
                if (base == `SAD_BASE_STACK)
                    dseg_nxt = SAD_SEG_STACK;
                if (base == `SAD_BASE_FRAME)
                begin
                    // Frame base slot is replaced by a dword displacement
                    base_used_nxt = 1'b0;
                    disp_size_nxt = SAD_DISP_DWORD;
                end
            end
            `SAD_FORM_BYTE:
            begin
                disp_size_nxt = SAD_DISP_BYTE;
                if (base == `SAD_BASE_STACK || base == `SAD_BASE_FRAME)
                    dseg_nxt = SAD_SEG_STACK;
            end
            `SAD_FORM_DWORD:
            begin
                disp_size_nxt = SAD_DISP_DWORD;
                if (base == `SAD_BASE_STACK || base == `SAD_BASE_FRAME)
                    dseg_nxt = SAD_SEG_STACK;
            end
            `SAD_FORM_REG:
            begin
                // Register form carries no memory operand
                base_used_nxt = 1'b0;
            end
        endcase

        base_val = base_used_nxt ? gpr_i[base] : '0;
        unique case (disp_size_nxt)
            SAD_DISP_BYTE:  disp_val = {{(ADDR_W-8){disp_i[7]}}, disp_i[7:0]};
            SAD_DISP_DWORD: disp_val = disp_i[ADDR_W-1:0];
            default:        disp_val = '0;
        endcase
        offset_nxt = base_val + scaled_idx + disp_val;
    end

    // ======================================================================
    // State registers
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            seg_narrow_r <= SAD_SEG_EXTRA;
            seg_wide_r   <= SAD_SEG_EXTRA;
            wide_undef_r <= 1'b0;
            sib_r        <= 1'b0;
            valid_r      <= 1'b0;
            dseg_r       <= SAD_SEG_DATA;
            base_used_r  <= 1'b0;
            base_reg_r   <= `SAD_RST_REG;
            idx_used_r   <= 1'b0;
            idx_reg_r    <= `SAD_RST_REG;
            factor_r     <= `SAD_RST_FACTOR;
            disp_size_r  <= SAD_DISP_NONE;
            offset_r     <= '0;
            undef_r      <= 1'b0;
        end
        else
        begin
            seg_narrow_r <= seg_narrow_nxt;
            seg_wide_r   <= seg_wide_nxt;
            wide_undef_r <= wide_undef_nxt;
            sib_r        <= sib_nxt;
            valid_r      <= valid_nxt;
            // Address results hold between requests
            if (valid_nxt)
            begin
                dseg_r      <= dseg_nxt;
                base_used_r <= base_used_nxt;
                base_reg_r  <= base_reg_nxt;
                idx_used_r  <= idx_used_nxt;
                idx_reg_r   <= idx_reg_nxt;
                factor_r    <= factor_nxt;
                disp_size_r <= disp_size_nxt;
                offset_r    <= offset_nxt;
                undef_r     <= undef_nxt;
            end
        end
    end

    assign seg_narrow_o     = seg_narrow_r;
    assign seg_wide_o       = seg_wide_r;
    assign seg_wide_undef_o = wide_undef_r;
    assign sib_follows_o    = sib_r;
    assign agen_valid_o     = valid_r;
    assign default_seg_o    = dseg_r;
    assign base_used_o      = base_used_r;
    assign base_reg_o       = base_reg_r;
    assign index_used_o     = idx_used_r;
    assign index_reg_o      = idx_reg_r;
    assign scale_factor_o   = factor_r;
    assign disp_size_o      = disp_size_r;
    assign ea_offset_o      = offset_r;
    assign ea_undef_o       = undef_r;

    // ======================================================================
    // Assertions
    sequence s_sib_req;
        dec_valid_i && modrm_i[2:0] == 3'h4 && modrm_i[7:6] != 2'h3;
    endsequence

    sequence s_sib_done;
        agen_valid_o && sib_follows_o;
    endsequence

    a_narrow_map: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        seg_sel_narrow_i == 2'h2 |=> seg_narrow_o == SAD_SEG_STACK)
        else $error("narrow code 10 did not give stack segment");

    a_wide_map: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        seg_sel_wide_i[2:1] == 2'h3 |=> seg_wide_undef_o && seg_wide_o == SAD_SEG_NONE)
        else $error("wide code 11x not flagged undefined");

    a_wide_extra: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        seg_sel_wide_i == 3'h5 |=> seg_wide_o == SAD_SEG_EXTRA_THREE && !seg_wide_undef_o)
        else $error("wide code 101 wrong segment");

    a_sib_detect: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        s_sib_req |=> s_sib_done)
        else $error("sib request not answered next cycle");

    a_no_sib_reg: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        modrm_i[7:6] == 2'h3 |=> !sib_follows_o && !agen_valid_o)
        else $error("register form taken as sib");

    a_scale_four: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (s_sib_req and (sib_i[7:6] == 2'h2)) |=> scale_factor_o == 4'h4)
        else $error("scale code 10 not x4");

    a_scale_eight: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (s_sib_req and (sib_i[7:6] == 2'h3)) |=> scale_factor_o == 4'h8)
        else $error("scale code 11 not x8");

    a_undef_idx: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (s_sib_req and (sib_i[5:3] == 3'h4))
            |=> !index_used_o && ea_undef_o == ($past(sib_i[7:6]) != 2'h0))
        else $error("no-index undefined flag wrong");

    a_frame_dword: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (s_sib_req and (modrm_i[7:6] == 2'h0 && sib_i[2:0] == 3'h5))
            |=> !base_used_o && disp_size_o == SAD_DISP_DWORD
                && default_seg_o == SAD_SEG_DATA)
        else $error("form 00 base 101 wrong");

    a_stack_seg: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (s_sib_req and (modrm_i[7:6] != 2'h0 && sib_i[2:1] == 2'h2))
            |=> default_seg_o == SAD_SEG_STACK)
        else $error("base 100/101 with displacement not stack");

    a_byte_disp: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (s_sib_req and (modrm_i[7:6] == 2'h1 && sib_i == 8'h24))
            |=> ea_offset_o == $past(gpr_i[4]) + {{24{$past(disp_i[7])}}, $past(disp_i[7:0])})
        else $error("byte displacement offset wrong");

    a_index_sum: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (s_sib_req and (modrm_i[7:6] == 2'h0 && sib_i == 8'hc8))
            |=> ea_offset_o == $past(gpr_i[0]) + ($past(gpr_i[1]) << 3))
        else $error("scaled index sum wrong");

    a_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        // A sequence cannot be negated, so the request is spelled out here
        !(dec_valid_i && modrm_i[2:0] == 3'h4 && modrm_i[7:6] != 2'h3)
            |=> $stable(ea_offset_o) && !agen_valid_o)
        else $error("result changed without request");

endmodule // sad_decode

// ---- verification/sad_fetch_model.sv ----
// Purpose: Fetch-side model presenting instruction bytes to the decoder
// Assumes: present is called shortly after a rising clock edge
// Notes:   Unqualified sib and displacement lines toggle, so stale data never looks valid
`timescale 1ns/100ps

module sad_fetch_model (
    // Request lines
    output logic                dec_valid_o,
    output logic [7:0]          modrm_o,
    output logic [7:0]          sib_o,
    output logic [31:0]         disp_o,
    // Segment codes and register file
    output logic [1:0]          narrow_o,
    output logic [2:0]          wide_o,
    output logic [7:0][31:0]    gpr_o
);
    // ==========================================================================
    // Idle state at time zero
    initial
    begin
        dec_valid_o = 1'b0;
        modrm_o     = 8'h00;
        sib_o       = 8'h00;
        disp_o      = 32'h0;
        narrow_o    = 2'h0;
        wide_o      = 3'h0;
        gpr_o       = '0;
    end

    // ==========================================================================
    // One cycle of fetch output; addressing byte, sib, displacement travel together
    task automatic present(input logic v, input logic [7:0] m, input logic [7:0] s,
                           input logic [31:0] d, input logic [4:0] sg,
                           input logic [7:0][31:0] g);
    begin
        dec_valid_o = v;
        modrm_o     = m;
        sib_o       = v ? s : ~sib_o;
        disp_o      = v ? d : ~disp_o;
        narrow_o    = sg[1:0];
        wide_o      = sg[4:2];
        gpr_o       = g;
    end
    endtask
endmodule // sad_fetch_model

// ---- verification/segment_and_sib_address_decode_bench.sv ----
// Purpose: Self-checking bench for the segment and sib address decoder
// Assumes: One-cycle registered results, address results hold between taken requests
// Notes:   Expected values come from an integer model evaluated every cycle
`timescale 1ns/100ps

module segment_and_sib_address_decode_bench
    import sad_pkg::*;
;
    // ==========================================================================
    // Signals
    logic               ref_clk = 1'b0;
    logic               rst     = 1'b1;
    logic               dv;
    logic [7:0]         modrm;
    logic [7:0]         sib;
    logic [31:0]        disp;
    logic [1:0]         nar;
    logic [2:0]         wid;
    logic [7:0][31:0]   gpr;
    logic [7:0][31:0]   g;
    sad_seg_t           seg_n;
    sad_seg_t           seg_w;
    sad_seg_t           def_seg;
    sad_disp_t          dsz;
    logic               wund, sibf, agv, bu, iu, eund;
    logic [2:0]         br, ir;
    logic [3:0]         fac;
    logic [31:0]        off;
    logic [31:0]        e_def, e_bu, e_br, e_iu, e_ir, e_fac, e_ds, e_off, e_und;
    int                 n_errors   = 0;
    int                 n_compared = 0;
    int                 i;
    int                 seed;

    always #25 ref_clk = ~ref_clk;

    sad_fetch_model sad_fetch_model_inst (
        .dec_valid_o (dv),
        .modrm_o     (modrm),
        .sib_o       (sib),
        .disp_o      (disp),
        .narrow_o    (nar),
        .wide_o      (wid),
        .gpr_o       (gpr)
    );

    sad_decode #(.ADDR_W(32)) sad_decode_inst (
        .ref_clk_i        (ref_clk),
        .reset_i          (rst),
        .seg_sel_narrow_i (nar),
        .seg_sel_wide_i   (wid),
        .dec_valid_i      (dv),
        .modrm_i          (modrm),
        .sib_i            (sib),
        .disp_i           (disp),
        .gpr_i            (gpr),
        .seg_narrow_o     (seg_n),
        .seg_wide_o       (seg_w),
        .seg_wide_undef_o (wund),
        .sib_follows_o    (sibf),
        .agen_valid_o     (agv),
        .default_seg_o    (def_seg),
        .base_used_o      (bu),
        .base_reg_o       (br),
        .index_used_o     (iu),
        .index_reg_o      (ir),
        .scale_factor_o   (fac),
        .disp_size_o      (dsz),
        .ea_offset_o      (off),
        .ea_undef_o       (eund)
    );

    // ==========================================================================
    // Checking and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask

    task automatic give_verdict();
    begin
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    // ==========================================================================
    // Model of one cycle, then compare after the edge
    task automatic step();
        int          f, b, x;
        logic        sf, ag;
        logic [31:0] dsp;
    begin
        f   = modrm[7:6];
        b   = sib[2:0];
        x   = sib[5:3];
        sf  = (modrm[2:0] == 3'h4) && (f != 3) && !rst;
        ag  = sf && dv;
        dsp = (f == 1) ? {{24{disp[7]}}, disp[7:0]} : (f == 2 || b == 5) ? disp : 32'h0;
        if (rst)
        begin
            {e_bu, e_br, e_iu, e_ir, e_ds, e_off, e_und} = '0;
            e_def = 3;
            e_fac = 1;
        end
        else if (ag)
        begin
            e_fac = 32'h1 << sib[7:6];
            e_iu  = (x != 4);
            e_ir  = x;
            e_br  = b;
            e_bu  = !(f == 0 && b == 5);
            e_ds  = (f == 0) ? ((b == 5) ? 2 : 0) : f;
            e_def = (b == 4 || (f != 0 && b == 5)) ? 3'h2 : 3'h3;
            e_und = !e_iu[0] && (sib[7:6] != 2'h0);
            e_off = (e_bu[0] ? gpr[b] : 32'h0) + (e_iu[0] ? gpr[x] * e_fac : 32'h0) + dsp;
        end
        @(posedge ref_clk);
        #1;
        check(seg_n, rst ? 32'h0 : {30'h0, nar});
        check(seg_w, rst ? 32'h0 : (wid > 3'h5) ? 32'h7 : {29'h0, wid});
        check(wund, rst ? 32'h0 : {31'h0, wid > 3'h5});
        check(sibf, {31'h0, sf});
        check(agv, {31'h0, ag});
        check(def_seg, e_def);
        check(bu, e_bu);
        check(br, e_br);
        check(iu, e_iu);
        check(ir, e_ir);
        check(fac, e_fac);
        check(dsz, e_ds);
        check(off, e_off);
        check(eund, e_und);
    end
    endtask

    task automatic send(input logic v, input logic [7:0] m, input logic [7:0] s,
                        input logic [4:0] sg);
    begin
        for (int k = 0; k < 8; k++)
            g[k] = $urandom;
        sad_fetch_model_inst.present(v, m, s, $urandom, sg, g);
        step();
    end
    endtask

    // ==========================================================================
    // Sequence
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        seed = $urandom(92);
        repeat (5) step();
        #0 rst = 1'b0;
        // Every form, base, scale and segment code, back to back; form 11 refused
        for (i = 0; i < 128; i++)
            send(1'b1, {i[6:5], 3'(i), 3'h4}, {i[1:0], i[0], i[6:5], i[4:2]}, i[4:0]);
        // Not taken: operand select other than 100, then no valid; results hold; then a taken form 01 request
        send(1'b1, 8'h85, 8'h5b, 5'h1f);
        send(1'b0, 8'h44, 8'h24, 5'h12);
        send(1'b1, 8'h44, 8'h24, 5'h07);
        // Form 00, scale x8 on index 001 over base 000
        send(1'b1, 8'h04, 8'hc8, 5'h0b);
        // Random traffic with a reset in mid-run
        for (i = 0; i < 600; i++)
        begin
            if (i == 300)
                rst = 1'b1;
            if (i == 302)
                rst = 1'b0;
            send(1'($urandom), (8'($urandom) | 8'h04) & ~{6'h0, 2'($urandom)}, 8'($urandom),
                 5'($urandom));
        end
        give_verdict();
    end
endmodule // segment_and_sib_address_decode_bench
